/* File: verilog/lsud_usb_dev.sv */
// Purpose: Low-speed USB function engine with packet DMA, events and link control
// Assumes: Line inputs synchronous to SYS_CLK; DMA memory answers with DMA_GNT
// Notes:   Register reads answer one cycle after the strobe
//
// The implementer's own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module lsud_usb_dev
  import lsud_pkg::*;
#(
  parameter int unsigned IDLE_SLEEP_REQUEST_LIMIT = IDLE_SLEEP_REQUEST_CYC
)
(
  input  wire logic               SYS_CLK,
  input  wire logic               RSTN,
  input  wire logic [3:0]         REG_ADDR,
  input  wire logic [7:0]         REG_WDATA,
  input  wire logic               REG_WR,
  input  wire logic               REG_RD,
  output logic      [7:0]         REG_RDATA,
  input  wire lsud_pkg::lsud_line_s LINE,
  output lsud_pkg::lsud_drv_s     DRV,
  output lsud_pkg::lsud_dma_s     DMA,
  input  wire logic               DMA_GNT,
  input  wire logic [7:0]         DMA_RDATA,
  input  wire logic               IRQ_DIS,
  output logic                    USB_IRQ,
  output logic                    WAKE_IRQ,
  output logic                    REG_OFF,
  output logic                    SUSPENDED
);
  import lsud_pkg::*;

  typedef struct packed {
    logic [7:0] rdata; logic [7:0] base; logic [1:0] bb; logic [1:0] ep; logic [3:0] cnt; logic [1:0] tp;
    logic [7:0] ev; logic [7:0] msk; logic [3:0] ctl; logic [6:0] fa; logic [2:0][7:0] ea; logic [2:0][7:0] eb;
    logic sarm; logic [19:0] idle; logic [9:0] se0c; logic eopd; logic force_bus_reset_q; logic res_q; logic pj;
    logic rxon; logic [7:0] rbc; logic rlast; logic [2:0] rones; logic [7:0] rsh; logic [2:0] rnb;
    logic [3:0] rby; logic serr; logic pidok; logic [3:0] pid; logic [7:0] d1; logic [7:0] d2;
    logic [4:0] c5; logic [15:0] c16; logic ovf; logic rlate;
    lsud_tr_e tr; logic [11:0] tmo; logic [1:0] cep; logic [1:0] ctp;
    logic txon; logic [1:0] tph; logic [7:0] tbc; logic tlvl; logic [2:0] tones; logic [7:0] tsh;
    logic [2:0] tnb; logic [3:0] tix; logic [3:0] tn; logic tdat; logic tfin; logic [15:0] tc16; logic [7:0] tbuf;
    logic dreq; logic dwr; logic [2:0] dslot; logic [2:0] dix; logic [7:0] dwd;
  } lsud_st_s;

  lsud_st_s   s, n;
  logic [7:0] ev_set;
  logic       live_j;

  function automatic logic [4:0] crc5s(input logic [4:0] c, input logic b);
    crc5s = {c[3:0], 1'b0} ^ ((b ^ c[4]) ? 5'h05 : 5'h00);
  endfunction : crc5s

  function automatic logic [15:0] crc16s(input logic [15:0] c, input logic b);
    crc16s = {c[14:0], 1'b0} ^ ((b ^ c[15]) ? 16'h8005 : 16'h0000);
  endfunction : crc16s

  function automatic logic [7:0] rev8(input logic [7:0] v);
    for (int i = 0; i < 8; i++)
      rev8[i] = v[7 - i];
  endfunction : rev8

  assign live_j = !LINE.k && !LINE.se0;

  // Next-state of registers, serial engine, transactions and DMA
  always_comb
  begin
    logic       b, go, brst, ack_ok, hit;
    logic [7:0] byt, src;
    logic [3:0] go_pid, go_n, nb, endp;
    logic [1:0] epi, st;
    n = s; ev_set = 8'h00; b = 1'b0; go = 1'b0; brst = 1'b0; ack_ok = 1'b0; hit = 1'b0;
    byt = 8'h00; src = 8'h00; go_pid = 4'h0; go_n = 4'h0; nb = 4'h0; endp = 4'h0; epi = 2'b00; st = 2'b00;
    n.rdata = 8'h00;
    n.force_bus_reset_q = s.ctl[C_FORCE_BUS_RESET];
    n.res_q = s.ctl[C_RES];
    n.pj = live_j;
    // Register reads, answered one cycle later
    if (REG_RD)
    begin
      if (REG_ADDR == A_BASE) n.rdata = s.base;
      else if (REG_ADDR == A_INFO) n.rdata = {s.bb, s.ep, s.cnt};
      else if (REG_ADDR == A_TOK) n.rdata = {s.tp, 3'b000, LINE.se0, LINE.k, 1'b0};
      else if (REG_ADDR == A_STAT) n.rdata = s.ev;
      else if (REG_ADDR == A_MASK) n.rdata = s.msk;
      else if (REG_ADDR == A_CTL) n.rdata = {4'h0, s.ctl};
      else if (REG_ADDR == A_FADR) n.rdata = {1'b0, s.fa};
      else if (REG_ADDR >= A_EP0A && REG_ADDR <= A_EP2B) n.rdata = REG_ADDR[0] ? s.eb[REG_ADDR[2:1]] : s.ea[REG_ADDR[2:1]];
    end
    // Register writes; hardware updates below take precedence
    if (REG_WR)
    begin
      if (REG_ADDR == A_BASE) n.base = REG_WDATA;
      else if (REG_ADDR == A_INFO) n.bb = REG_WDATA[7:6];
      else if (REG_ADDR == A_STAT) n.ev = s.ev & REG_WDATA;
      else if (REG_ADDR == A_MASK) n.msk = REG_WDATA;
      else if (REG_ADDR == A_CTL) n.ctl = REG_WDATA[3:0];
      else if (REG_ADDR == A_FADR) n.fa = REG_WDATA[6:0];
      else if (REG_ADDR >= A_EP0A && REG_ADDR <= A_EP2B)
      begin
        if (REG_ADDR[0]) n.eb[REG_ADDR[2:1]] = REG_WDATA;
        else n.ea[REG_ADDR[2:1]] = REG_WDATA;
      end
    end
    // DMA grant completes the pending memory access
    if (s.dreq && DMA_GNT)
    begin
      n.dreq = 1'b0;
      if (!s.dwr) n.tbuf = DMA_RDATA;
    end
    // SE0 length: bus reset or keep-alive strobe
    if (LINE.se0 && !DRV.oe)
    begin
      if (s.se0c != BRST_CYC) n.se0c = s.se0c + 10'd1;
      if (s.se0c == BRST_CYC - 10'd1)
      begin
        brst = 1'b1;
        ev_set[E_RST] = 1'b1;
      end
    end
    else
    begin
      n.se0c = 10'd0;
      if (s.se0c != 10'd0 && s.se0c < BRST_CYC && !s.eopd) ev_set[E_SOF] = 1'b1;
      if (s.se0c != 10'd0) n.eopd = 1'b0;
    end
    // Suspend request after long idle, armed by reset
    if (!live_j || !s.sarm || s.ctl[C_FS]) n.idle = 20'd0;
    else if (s.idle != 20'(IDLE_SLEEP_REQUEST_LIMIT))
    begin
      n.idle = s.idle + 20'd1;
      if (s.idle == 20'(IDLE_SLEEP_REQUEST_LIMIT) - 20'd1) ev_set[E_IDLE_SLEEP_REQUEST] = 1'b1;
    end
    if (s.ctl[C_FS]) n.sarm = 1'b0;
    // Wake on activity while suspended
    if (s.ctl[C_FS] && !live_j && !s.ctl[C_RES])
    begin
      ev_set[E_WAKE] = 1'b1;
      n.ctl[C_FS] = 1'b0;
    end
    // End of resume signalling
    if (s.res_q && !s.ctl[C_RES])
    begin
      ev_set[E_SOF] = 1'b1;
      n.sarm = 1'b1;
    end
    if (s.force_bus_reset_q && !s.ctl[C_FORCE_BUS_RESET]) ev_set[E_RST] = 1'b1;
    // Transaction timeout while waiting for the host
    if ((s.tr == T_WDAT || s.tr == T_WACK) && !s.rxon)
    begin
      n.tmo = s.tmo + 12'd1;
      if (s.tmo == TMO_CYC)
      begin
        ev_set[E_ERR] = 1'b1;
        n.tr = T_IDLE;
      end
    end
    // Receiver: sync start, mid-bit sampling, NRZI, unstuffing, CRC
    if (!DRV.oe && !s.txon)
    begin
      if (!s.rxon)
      begin
        if (s.pj && LINE.k && !LINE.se0)
        begin
          n.rxon = 1'b1; n.rbc = BIT_CYC >> 1; n.rlast = 1'b0; n.rones = 3'd0; n.rnb = 3'd0;
          n.rby = 4'd0; n.serr = 1'b0; n.ovf = 1'b0; n.rlate = 1'b0; n.tmo = 12'd0;
        end
      end
      else if (s.rbc != 8'd0) n.rbc = s.rbc - 8'd1;
      else if (LINE.se0)
      begin
        n.rxon = 1'b0;
        n.eopd = 1'b1;
        endp = {s.d1[2:0], s.d2[7]};
        if (endp == 4'h0) begin hit = 1'b1; epi = 2'd0; end
        else if (endp == s.eb[1][3:0]) begin hit = 1'b1; epi = 2'd1; end
        else if (endp == s.eb[2][3:0]) begin hit = 1'b1; epi = 2'd2; end
        // Packet end: framing, PID and stuffing faults, then protocol step
        if (!s.pidok || s.serr || s.rnb != 3'd0 || s.rby < 4'd2)
        begin
          ev_set[E_ERR] = 1'b1;
          n.tr = T_IDLE;
        end
        else if (s.tr == T_IDLE && s.pid[1:0] == 2'b01)
        begin
          if (s.rby != 4'd4 || s.c5 != CRC5_RES) ev_set[E_ERR] = 1'b1;
          else if (s.d2[6:0] == s.fa && hit)
          begin
            n.cep = epi; n.ctp = s.pid[3:2]; n.tp = s.pid[3:2];
            st = s.ea[epi][5:4];
            if (s.pid == PID_IN)
            begin
              go = (st != 2'b00);
              go_pid = (st == ST_VAL) ? (s.ea[epi][6] ? PID_D1 : PID_D0) : (st == ST_NAK ? PID_NAK : PID_STALL);
              go_n = (st != ST_VAL) ? 4'd0 : (s.ea[epi][3:0] > 4'd8 ? 4'd8 : s.ea[epi][3:0]);
            end
            else
            begin
              n.tr = T_WDAT;
              if (s.pid[3:2] == TP_SETUP) n.eb[epi][6] = 1'b0;
            end
          end
        end
        else if (s.tr == T_WDAT && s.pid[2:0] == 3'b011)
        begin
          n.tr = T_IDLE;
          st = s.eb[s.cep][5:4];
          if (s.c16 != CRC16_RES || s.ovf || s.rlate || s.rby < 4'd4) ev_set[E_ERR] = s.c16 != CRC16_RES;
          else if (s.ctp == TP_SETUP || (st == ST_VAL && !(s.ea[s.cep][7] && s.rby != 4'd4)))
          begin
            go = 1'b1; go_pid = PID_ACK;
            n.cnt = s.rby - 4'd4;
            if (s.pid[3] == n.eb[s.cep][6])
            begin
              ev_set[E_CTR] = 1'b1; n.ep = s.cep;
              n.eb[s.cep][6] = !n.eb[s.cep][6];
              n.eb[s.cep][5:4] = ST_NAK;
              if (s.ctp == TP_SETUP)
              begin
                n.ea[s.cep][6] = 1'b1;
                n.ea[s.cep][5:4] = ST_NAK;
              end
            end
          end
          else if (st != 2'b00)
          begin
            go = 1'b1;
            go_pid = (st == ST_NAK) ? PID_NAK : PID_STALL;
          end
        end
        else if (s.tr == T_WACK)
        begin
          n.tr = T_IDLE;
          if (s.pid == PID_ACK && s.rby == 4'd2)
          begin
            ev_set[E_CTR] = 1'b1; n.ep = s.cep;
            n.ea[s.cep][6] = !s.ea[s.cep][6];
            n.ea[s.cep][5:4] = ST_NAK;
          end
          else ev_set[E_ERR] = 1'b1;
        end
      end
      else
      begin
        n.rbc = BIT_CYC - 8'd1;
        b = (LINE.k == s.rlast);
        n.rlast = LINE.k;
        if (s.rones == 3'd6)
        begin
          n.rones = 3'd0;
          if (b) n.serr = 1'b1;
        end
        else
        begin
          n.rones = b ? s.rones + 3'd1 : 3'd0;
          n.rsh = {b, s.rsh[7:1]};
          n.rnb = s.rnb + 3'd1;
          if (s.rby >= 4'd2)
          begin
            n.c5 = crc5s(s.c5, b);
            n.c16 = crc16s(s.c16, b);
          end
          if (s.rnb == 3'd7)
          begin
            byt = {b, s.rsh[7:1]};
            n.rby = (s.rby == 4'hf) ? s.rby : s.rby + 4'd1;
            n.d1 = byt;
            n.d2 = s.d1;
            if (s.rby == 4'd1)
            begin
              n.pid = byt[3:0]; n.pidok = (byt[7:4] == ~byt[3:0]); n.c5 = 5'h1f; n.c16 = 16'hffff;
            end
            if (s.tr == T_WDAT && s.rby >= 4'd4)
            begin
              if (s.rby >= 4'd12) n.ovf = 1'b1;
              else if (s.dreq && !DMA_GNT)
              begin
                ev_set[E_DMA_LATE_FLAG] = 1'b1;
                n.rlate = 1'b1;
              end
              else
              begin
                n.dreq = 1'b1; n.dwr = 1'b1; n.dslot = {s.cep, 1'b0};
                n.dix = 3'(s.rby - 4'd4); n.dwd = s.d2;
              end
            end
          end
        end
      end
    end
    // Transmitter launch: handshake or data packet
    if (go)
    begin
      n.txon = 1'b1; n.tph = 2'd0; n.tbc = BIT_CYC - 8'd1; n.tlvl = 1'b0; n.tones = 3'd0; n.tsh = SYNC;
      n.tnb = 3'd0; n.tix = 4'd0; n.tn = go_n; n.tdat = (go_pid[1:0] == 2'b11); n.tfin = 1'b0;
      n.tc16 = 16'hffff; n.ctp = (go_pid[1:0] == 2'b11) ? s.ctp : s.ctp; n.pid = go_pid; n.tr = T_TX;
      if (go_n != 4'd0)
      begin
        n.dreq = 1'b1; n.dwr = 1'b0; n.dslot = {n.cep, 1'b1}; n.dix = 3'd0;
      end
    end
    // Transmitter bit slots: stuffing, NRZI, CRC, EOP
    else if (s.txon)
    begin
      if (s.tbc != 8'd0) n.tbc = s.tbc - 8'd1;
      else
      begin
        n.tbc = BIT_CYC - 8'd1;
        if (s.tph == 2'd2)
        begin
          n.txon = 1'b0; n.eopd = 1'b1; n.tmo = 12'd0;
          n.tr = s.tdat ? T_WACK : T_IDLE;
        end
        else if (s.tph == 2'd1)
        begin
          if (s.tnb == 3'd1) n.tph = 2'd2;
          n.tnb = 3'd1;
        end
        else if (s.tones == 3'd6)
        begin
          n.tlvl = !s.tlvl; n.tones = 3'd0;
        end
        else if (s.tfin)
        begin
          n.tph = 2'd1; n.tnb = 3'd0;
        end
        else
        begin
          b = s.tsh[0];
          n.tlvl = b ? s.tlvl : !s.tlvl;
          n.tones = b ? s.tones + 3'd1 : 3'd0;
          n.tsh = s.tsh >> 1;
          n.tnb = s.tnb + 3'd1;
          if (s.tix >= 4'd2 && s.tix < s.tn + 4'd2) n.tc16 = crc16s(s.tc16, b);
          if (s.tnb == 3'd7)
          begin
            nb = s.tix + 4'd1;
            n.tix = nb;
            src = (s.dreq && DMA_GNT) ? DMA_RDATA : s.tbuf;
            if (nb == 4'd1) n.tsh = {~s.pid, s.pid};
            else if (!s.tdat || nb > s.tn + 4'd3) n.tfin = 1'b1;
            else if (nb < s.tn + 4'd2)
            begin
              n.tsh = src;
              if (s.dreq && !DMA_GNT) ev_set[E_DMA_LATE_FLAG] = 1'b1;
              if (nb < s.tn + 4'd1)
              begin
                n.dreq = 1'b1; n.dwr = 1'b0; n.dix = 3'(nb - 4'd1);
              end
            end
            else if (nb == s.tn + 4'd2) n.tsh = rev8(~n.tc16[15:8]);
            else n.tsh = rev8(~s.tc16[7:0]);
          end
        end
      end
    end
    // Bus reset or forced reset: clear address, endpoints and engine
    if (brst || s.ctl[C_FORCE_BUS_RESET])
    begin
      n.fa = 7'h00; n.ea = '0; n.eb = {8'h00, 8'h00, EP0B_RST}; n.rxon = 1'b0; n.txon = 1'b0;
      n.tr = T_IDLE; n.dreq = 1'b0; n.sarm = 1'b1; n.idle = 20'd0;
    end
    n.eb[0][7] = 1'b1;
    n.eb[0][3:0] = 4'h0;
    // Overrun of fault and frame flags
    if ((ev_set[E_ERR] && s.ev[E_ERR]) || (ev_set[E_SOF] && s.ev[E_SOF])) ev_set[E_EVENT_OVERRUN_FLAG] = 1'b1;
    n.ev = n.ev | ev_set;
  end

  // State register
  always_ff @(posedge SYS_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      s       <= '0;
      s.ctl   <= CTL_RST;
      s.eb[0] <= EP0B_RST;
      s.sarm  <= 1'b1;
      s.tr    <= T_IDLE;
    end
    else
      s <= n;
  end

  // Outputs
  assign REG_RDATA = s.rdata;
  assign DRV.oe    = s.txon || s.ctl[C_RES];
  assign DRV.k     = s.ctl[C_RES] || (s.txon && s.tph == 2'd0 && s.tlvl);
  assign DRV.se0   = !s.ctl[C_RES] && s.txon && s.tph == 2'd1;
  assign DMA.req   = s.dreq;
  assign DMA.wr    = s.dwr;
  assign DMA.addr  = {s.base, s.bb, s.dslot, s.dix};
  assign DMA.wdata = s.dwd;
  assign USB_IRQ   = !IRQ_DIS && |(s.ev & s.msk & ~(8'h01 << E_WAKE));
  assign WAKE_IRQ  = !IRQ_DIS && s.ev[E_WAKE] && s.msk[E_WAKE];
  assign REG_OFF   = s.ctl[C_REGULATOR_OFF];
  assign SUSPENDED = s.ctl[C_FS];

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RSTN);

  chk_flag_no_set: assert property ((REG_WR && REG_ADDR == A_STAT) |=> (s.ev & ~$past(s.ev) & ~$past(ev_set)) == 8'h00) else $error("flag set by write");
  chk_ctl_high_zero: assert property ((REG_RD && REG_ADDR == A_CTL) |=> REG_RDATA[7:4] == 4'h0) else $error("control upper bits nonzero");
  chk_tp_code: assert property (s.tp != 2'b01) else $error("bad token code");
  chk_ep_code: assert property ($rose(s.ev[E_CTR]) |-> s.ep != 2'b11) else $error("bad endpoint id");
  chk_rx_count: assert property (s.cnt <= 4'd8) else $error("count above eight");
  chk_force_bus_reset_hold: assert property (s.ctl[C_FORCE_BUS_RESET] |=> s.fa == 7'h00 && s.tr == T_IDLE && !DRV.se0) else $error("forced reset not held");
  chk_force_bus_reset_event: assert property ($fell(s.ctl[C_FORCE_BUS_RESET]) |=> s.ev[E_RST]) else $error("no reset event");
  chk_irq_gate: assert property (IRQ_DIS |-> !USB_IRQ && !WAKE_IRQ) else $error("interrupt while disabled");
  chk_resume_k: assert property (s.ctl[C_RES] |-> DRV.oe && DRV.k && !DRV.se0) else $error("resume not driven");
  chk_dma_window: assert property (DMA.req |-> DMA.addr[15:6] == {s.base, s.bb} && DMA.addr[5:4] != 2'b11) else $error("dma outside window");
  chk_wake_clear: assert property ((s.ctl[C_FS] && !live_j && !s.ctl[C_RES]) |=> !s.ctl[C_FS] && s.ev[E_WAKE]) else $error("wake missed");
  cov_good: cover property ($rose(s.ev[E_CTR]));
  cov_idle_sleep_request: cover property ($rose(s.ev[E_IDLE_SLEEP_REQUEST]));
  cov_txdat: cover property (s.txon && s.tdat && s.tix == 4'd3);
endmodule : lsud_usb_dev

/* File: pkg/lsud_pkg.sv */
// Purpose: Shared constants and carrier types of the low-speed USB function block
// Assumes: 250 MHz system clock, 1.5 Mbit/s low-speed bus
// Notes:   Register offsets are addresses on the plain register port
package lsud_pkg;
  localparam int unsigned CLK_HZ    = 250_000_000;
  localparam int unsigned BIT_HZ    = 1_500_000;
  localparam logic [7:0]  BIT_CYC   = 8'(CLK_HZ / BIT_HZ);
  localparam int unsigned IDLE_SLEEP_REQUEST_MS   = 3;
  localparam int unsigned IDLE_SLEEP_REQUEST_CYC  = IDLE_SLEEP_REQUEST_MS * (CLK_HZ / 1000);
  localparam int unsigned BRST_NS   = 2500;
  localparam logic [9:0]  BRST_CYC  = 10'((BRST_NS * (CLK_HZ / 1_000_000) + 999) / 1000);
  localparam int unsigned TMO_BITS  = 18;
  localparam logic [11:0] TMO_CYC   = 12'(TMO_BITS * (CLK_HZ / BIT_HZ));
  // Register offsets
  localparam logic [3:0]  A_BASE    = 4'h0;
  localparam logic [3:0]  A_INFO    = 4'h1;
  localparam logic [3:0]  A_TOK     = 4'h2;
  localparam logic [3:0]  A_STAT    = 4'h3;
  localparam logic [3:0]  A_MASK    = 4'h4;
  localparam logic [3:0]  A_CTL     = 4'h5;
  localparam logic [3:0]  A_FADR    = 4'h6;
  localparam logic [3:0]  A_EP0A    = 4'h8;
  localparam logic [3:0]  A_EP2B    = 4'hd;
  // Event bit positions
  localparam int unsigned E_SOF     = 0;
  localparam int unsigned E_RST     = 1;
  localparam int unsigned E_WAKE    = 2;
  localparam int unsigned E_EVENT_OVERRUN_FLAG    = 3;
  localparam int unsigned E_ERR     = 4;
  localparam int unsigned E_CTR     = 5;
  localparam int unsigned E_DMA_LATE_FLAG    = 6;
  localparam int unsigned E_IDLE_SLEEP_REQUEST    = 7;
  // Control bit positions and reset values
  localparam int unsigned C_FORCE_BUS_RESET    = 0;
  localparam int unsigned C_FS      = 1;
  localparam int unsigned C_REGULATOR_OFF    = 2;
  localparam int unsigned C_RES     = 3;
  localparam logic [3:0]  CTL_RST   = 4'h6;
  localparam logic [7:0]  EP0B_RST  = 8'h80;
  // Packet identifiers and handshake states
  localparam logic [3:0]  PID_IN    = 4'h9;
  localparam logic [3:0]  PID_ACK   = 4'h2;
  localparam logic [3:0]  PID_NAK   = 4'ha;
  localparam logic [3:0]  PID_STALL = 4'he;
  localparam logic [3:0]  PID_D0    = 4'h3;
  localparam logic [3:0]  PID_D1    = 4'hb;
  localparam logic [1:0]  TP_SETUP  = 2'h3;
  localparam logic [1:0]  ST_STALL  = 2'h1;
  localparam logic [1:0]  ST_NAK    = 2'h2;
  localparam logic [1:0]  ST_VAL    = 2'h3;
  localparam logic [7:0]  SYNC      = 8'h80;
  localparam logic [4:0]  CRC5_RES  = 5'h0c;
  localparam logic [15:0] CRC16_RES = 16'h800d;

  typedef enum logic [1:0] {T_IDLE = 2'b00, T_WDAT = 2'b01, T_TX = 2'b10, T_WACK = 2'b11} lsud_tr_e;

  typedef struct packed {logic k; logic se0;} lsud_line_s;
  typedef struct packed {logic oe; logic k; logic se0;} lsud_drv_s;
  typedef struct packed {logic req; logic wr; logic [15:0] addr; logic [7:0] wdata;} lsud_dma_s;
endpackage : lsud_pkg

/* File: testbench/lsud_host_model.sv */
// Purpose: Behavioural low-speed host that drives the bus line state
// Assumes: Device samples the line on SYS_CLK
// Notes:   Idle is J; the host ignores DRV and can keep driving while the device drives the bus
`timescale 1ns/1ps
module lsud_host_model
(
  input  wire logic                SYS_CLK,
  input  wire lsud_pkg::lsud_drv_s DRV,
  output lsud_pkg::lsud_line_s     LINE
);
  import lsud_pkg::*;
  initial LINE = '0;
  // Hold one line state for n cycles, then release the bus back to idle J
  task automatic line_hold(input logic k, input logic se0, input int unsigned n);
    @(posedge SYS_CLK);
    LINE <= '{k: k, se0: se0};
    repeat (n) @(posedge SYS_CLK);
    LINE <= '0;
  endtask : line_hold
  // Send bytes LSB first from byte 0 (sync) with NRZI and stuffing, then EOP and one idle bit
  task automatic pkt(input logic [87:0] bits, input int unsigned nbytes);
    logic        lvl;
    int unsigned ones;
    lvl  = 1'b0;
    ones = 0;
    @(posedge SYS_CLK);
    for (int unsigned i = 0; i < 8 * nbytes; i++)
    begin
      if (!bits[i]) lvl = !lvl;
      ones = bits[i] ? ones + 1 : 0;
      LINE <= '{k: lvl, se0: 1'b0};
      repeat (BIT_CYC) @(posedge SYS_CLK);
      if (ones == 6)
      begin
        lvl  = !lvl;
        ones = 0;
        LINE <= '{k: lvl, se0: 1'b0};
        repeat (BIT_CYC) @(posedge SYS_CLK);
      end
    end
    LINE <= '{k: 1'b0, se0: 1'b1};
    repeat (2 * BIT_CYC) @(posedge SYS_CLK);
    LINE <= '0;
    repeat (BIT_CYC) @(posedge SYS_CLK);
  endtask : pkt
endmodule : lsud_host_model

/* File: testbench/tb.sv */
// Purpose: Register-level test of the low-speed USB function block
// Assumes: Host model drives line states; memory grants DMA at once
// Notes:   Short suspend limit keeps the idle test brief
`timescale 1ns/1ps
module tb;
  import lsud_pkg::*;
  localparam int unsigned SLIM = 2000;
  logic       sys_clk, rstn, reg_wr, reg_rd, irq_dis, usb_irq, wake_irq, reg_off, suspended;
  logic [3:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  lsud_line_s host_line, line_w;
  lsud_drv_s  drv;
  lsud_dma_s  dma;
  int         err_total, checked, dma_n, se0_n;
  logic [15:0] dma_a, dma_d;
  // Wire level: the device wins while it drives, else the host
  assign line_w = drv.oe ? lsud_line_s'{k: drv.k, se0: drv.se0} : host_line;
  // Memory side grants at once; record DMA writes and driven SE0 cycles
  always @(posedge sys_clk)
  begin
    if (dma.req && dma.wr)
    begin
      dma_n <= dma_n + 1;
      dma_a <= dma.addr;
      dma_d <= {dma_d[7:0], dma.wdata};
    end
    if (drv.se0) se0_n <= se0_n + 1;
  end
  lsud_usb_dev #(.IDLE_SLEEP_REQUEST_LIMIT(SLIM)) lsud_usb_dev_i (.SYS_CLK(sys_clk), .RSTN(rstn), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .LINE(line_w),
    .DRV(drv), .DMA(dma), .DMA_GNT(dma.req), .DMA_RDATA(dma.addr[7:0]), .IRQ_DIS(irq_dis),
    .USB_IRQ(usb_irq), .WAKE_IRQ(wake_irq), .REG_OFF(reg_off), .SUSPENDED(suspended));
  lsud_host_model lsud_host_model_i (.SYS_CLK(sys_clk), .DRV(drv), .LINE(host_line));
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  // Bus CRC16 of two data bytes, reflected form, complemented, low byte sent first
  function automatic logic [15:0] crc16_of(input logic [15:0] d);
    logic [15:0] c;
    c = 16'hffff;
    for (int i = 0; i < 16; i++)
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return ~c;
  endfunction : crc16_of
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand in the cycle after the strobe only
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask : rd
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  // Run limit
  initial
  begin
    cyc(100000);
    err_total++;
    end_sim();
  end
  initial
  begin
    rstn = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 8'h00; irq_dis = 1'b0;
    cyc(2);
    rstn <= 1'b1;
    rd(A_CTL);  chk("ctl reset", 8'h06, v);
    rd(A_STAT); chk("status reset", 8'h00, v);
    rd(A_MASK); chk("mask reset", 8'h00, v);
    rd(4'h9);   chk("ep0 b reset", 8'h80, v);
    rd(4'h7);   chk("unmapped", 8'h00, v);
    chk("reg off", 8'h01, {7'h0, reg_off});
    chk("suspended", 8'h01, {7'h0, suspended});
    wr(A_CTL, 8'hf4);
    rd(A_CTL);  chk("ctl upper", 8'h04, v);
    wr(A_CTL, 8'h00);
    cyc(1);     chk("reg on", 8'h00, {7'h0, reg_off});
    $display("test reset values done");
    // Two keep-alive strobes without clearing
    repeat (2)
    begin
      lsud_host_model_i.line_hold(1'b0, 1'b1, 2 * BIT_CYC);
      cyc(400);
    end
    rd(A_STAT); chk("sof and overrun", 8'h09, v & 8'h09);
    wr(A_STAT, 8'h00);
    wr(A_STAT, 8'hff);
    rd(A_STAT); chk("write one keeps", 8'h00, v);
    $display("test keep-alive done");
    wr(A_FADR, 8'h55);
    wr(4'ha, 8'h35);
    wr(4'hb, 8'h31);
    rd(A_FADR); chk("address", 8'h55, v);
    rd(4'hb);   chk("ep1 number", 8'h31, v);
    wr(A_CTL, 8'h01);
    wr(A_FADR, 8'h22);
    rd(A_FADR); chk("address held", 8'h00, v);
    wr(A_MASK, 8'h02);
    wr(A_CTL, 8'h00);
    cyc(3);
    rd(A_STAT); chk("reset flag", 8'h02, v & 8'h02);
    rd(4'ha);   chk("ep1 a cleared", 8'h00, v);
    rd(4'hb);   chk("ep1 b cleared", 8'h00, v);
    chk("usb irq", 8'h01, {7'h0, usb_irq});
    cyc(1);
    irq_dis <= 1'b1;
    cyc(1);     chk("usb irq off", 8'h00, {7'h0, usb_irq});
    irq_dis <= 1'b0;
    $display("test forced reset done");
    wr(A_STAT, 8'h00);
    cyc(SLIM + 50);
    rd(A_STAT); chk("suspend request", 8'h80, v & 8'h80);
    wr(A_CTL, 8'h02);
    wr(A_STAT, 8'h00);
    cyc(SLIM + 50);
    rd(A_STAT); chk("no request asleep", 8'h00, v & 8'h80);
    $display("test idle done");
    wr(A_MASK, 8'h04);
    fork
      lsud_host_model_i.line_hold(1'b1, 1'b0, 20);
      begin
        cyc(10);
        rd(A_TOK); chk("line k", 8'h02, v & 8'h06);
      end
    join
    cyc(5);
    rd(A_STAT); chk("wake flag", 8'h04, v & 8'h04);
    chk("wake irq", 8'h01, {7'h0, wake_irq});
    chk("sleep cleared", 8'h00, {7'h0, suspended});
    wr(A_STAT, 8'hfb);
    rd(A_STAT); chk("wake cleared", 8'h00, v & 8'h04);
    $display("test wake done");
    wr(A_STAT, 8'h00);
    wr(A_CTL, 8'h08);
    cyc(2);     chk("resume drive", 8'h03, {6'h0, drv.oe, drv.k});
    wr(A_CTL, 8'h00);
    cyc(3);
    rd(A_STAT); chk("resume end sof", 8'h01, v & 8'h01);
    $display("test resume done");
    wr(A_FADR, 8'h11);
    wr(A_STAT, 8'h00);
    fork
      lsud_host_model_i.line_hold(1'b0, 1'b1, BRST_CYC + 40);
      begin
        cyc(100);
        rd(A_TOK); chk("line se0", 8'h04, v & 8'h06);
      end
    join
    cyc(5);
    rd(A_STAT); chk("bus reset flag", 8'h02, v & 8'h02);
    rd(A_FADR); chk("address reset", 8'h00, v);
    $display("test bus reset done");
    // SETUP to address 0 endpoint 0, then DATA0 with two bytes
    wr(A_BASE, 8'h12);
    wr(A_INFO, 8'h40);
    wr(A_STAT, 8'h00);
    lsud_host_model_i.pkt(88'h10_00_2d_80, 4);
    lsud_host_model_i.pkt(88'({crc16_of(16'ha75a), 16'ha75a, 8'hc3, SYNC}), 6);
    cyc(20 * BIT_CYC);
    rd(A_STAT); chk("good flag", 8'h20, v & 8'h20);
    rd(A_INFO); chk("endpoint and count", 8'h42, v);
    rd(A_TOK);  chk("setup pid", 8'hc0, v & 8'hc0);
    rd(4'h9);   chk("ep0 b after", 8'he0, v);
    rd(4'h8);   chk("ep0 a after", 8'h60, v);
    chk("dma writes", 8'h02, 8'(dma_n));
    chk("dma addr hi", 8'h12, dma_a[15:8]);
    chk("dma addr lo", 8'h41, dma_a[7:0]);
    chk("dma byte 0", 8'h5a, dma_d[15:8]);
    chk("dma byte 1", 8'ha7, dma_d[7:0]);
    chk("ack eop", 8'h01, {7'h0, se0_n == 2 * BIT_CYC});
    $display("test setup transfer done");
    end_sim();
  end
endmodule : tb
